// File: rtl/erf_rx_filter.sv
/*
  Receive frame filter configuration, buffer watermarks and receive
  activity status with an APB register slave and one interrupt line.
  Assumes frame start/end strobes and per-frame qualifiers from the
  receive datapath, and a buffer count from the descriptor logic.
*/
`timescale 1ns/10ps
module erf_rx_filter
  import erf_pkg::*;
#(
  parameter int COUNT_W = 8
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rstn,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Receive datapath.
  input wire logic i_frame_start,
  input wire logic i_frame_end,
  input wire logic i_frame_abort,
  input wire erf_frame_t i_frame,
  input wire logic [COUNT_W-1:0] i_rx_buffer_count,
  // Results.
  output logic o_frame_accept,
  output logic o_frame_reject,
  output logic o_pattern_match,
  output logic o_hash_filter_on,
  output logic o_wake_filter_on,
  output logic o_flow_ctl,
  output logic o_irq
);

  // The mark fields are eight bits wide, so the count has to match them.
  if (COUNT_W != 8) begin : g_count_w_check
    $error("erf_rx_filter: COUNT_W must be 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus decode.

  logic [31:0] filter_r;
  logic [31:0] wmark_r;
  logic [31:0] ctrl_r;
  logic [ERF_IRQ_W-1:0] irq_stat_r;
  logic [ERF_IRQ_W-1:0] irq_mask_r;
  erf_state_t state_r;
  logic flow_r;
  logic full_r;
  logic empty_r;
  logic [31:0] status_w;
  logic [31:0] rdata_nxt;
  logic wr_en;
  logic rd_en;
  logic hit;

  // The slave answers in the first access cycle, so pready is tied high.
  assign o_pready = 1'b1;
  assign wr_en = i_psel & i_penable & i_pwrite;
  assign rd_en = i_psel & ~i_penable & ~i_pwrite;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] wmask);
    merge = (old_v & ~wmask) | (new_v & wmask);
  endfunction : merge

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      filter_r <= ERF_FILTER_RESET;
    end else if (wr_en && i_paddr == ERF_OFS_FILTER) begin
      // Software is expected to write only with receive disabled.
      filter_r <= merge(filter_r, i_pwdata, ERF_FILTER_WMASK);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      wmark_r <= ERF_WMARK_RESET;
    end else if (wr_en && i_paddr == ERF_OFS_WMARK) begin
      wmark_r <= merge(wmark_r, i_pwdata, ERF_WMARK_WMASK);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      ctrl_r <= ERF_CTRL_RESET;
    end else if (wr_en && i_paddr == ERF_OFS_CTRL) begin
      ctrl_r <= merge(ctrl_r, i_pwdata, ERF_CTRL_WMASK);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      irq_mask_r <= ERF_IRQ_RESET;
    end else if (wr_en && i_paddr == ERF_OFS_IRQ_MASK) begin
      irq_mask_r <= i_pwdata[ERF_IRQ_W-1:0];
    end
  end

  always_comb begin
    status_w = 32'h0000_0000;
    status_w[ERF_ACTIVE_BIT] = (state_r == ERF_BUSY) & ctrl_r[ERF_ON_BIT];
    status_w[ERF_FC_BIT] = flow_r;
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    o_pslverr = 1'b0;
    if (i_paddr == ERF_OFS_FILTER) begin
      rdata_nxt = filter_r;
    end else if (i_paddr == ERF_OFS_WMARK) begin
      rdata_nxt = wmark_r;
    end else if (i_paddr == ERF_OFS_STATUS) begin
      rdata_nxt = status_w;
    end else if (i_paddr == ERF_OFS_CTRL) begin
      rdata_nxt = ctrl_r;
    end else if (i_paddr == ERF_OFS_IRQ_STAT) begin
      rdata_nxt = {29'h0, irq_stat_r};
    end else if (i_paddr == ERF_OFS_IRQ_MASK) begin
      rdata_nxt = {29'h0, irq_mask_r};
    end else begin
      o_pslverr = i_psel & i_penable;
    end
  end

  // Read data is captured in the setup cycle and held for the access cycle.
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      o_prdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pattern match and acceptance.

  logic [3:0] mode;
  logic csum_ok;
  logic pm_nxt;
  logic cls_ok;

  assign mode = filter_r[ERF_MODE_LSB +: 4];
  assign csum_ok = filter_r[ERF_INVERT_BIT] ^ i_frame.csum_match;
  assign o_hash_filter_on = filter_r[ERF_HASH_EN_BIT];
  assign o_wake_filter_on = filter_r[ERF_WAKE_EN_BIT];

  always_comb begin
    case (mode)
      ERF_PM_OFF: pm_nxt = 1'b0;
      ERF_PM_PLAIN: pm_nxt = csum_ok;
      ERF_PM_STN_A, ERF_PM_STN_B: pm_nxt = csum_ok & i_frame.station_hit;
      ERF_PM_UNI_A, ERF_PM_UNI_B: pm_nxt = csum_ok & i_frame.cls.unicast;
      ERF_PM_BC_A, ERF_PM_BC_B: pm_nxt = csum_ok & i_frame.cls.broadcast;
      ERF_PM_HASH: pm_nxt = csum_ok & i_frame.hash_hit;
      ERF_PM_WAKE: pm_nxt = csum_ok & i_frame.wake_pkt;
      default: pm_nxt = 1'b0;
    endcase
  end

  // A frame is taken when its class is enabled, a filter it has enabled
  // hits, or the pattern match succeeds.
  assign cls_ok = |(erf_class_t'(filter_r[7:0]) & i_frame.cls);
  assign hit = cls_ok | pm_nxt
    | (filter_r[ERF_HASH_EN_BIT] & i_frame.hash_hit)
    | (filter_r[ERF_WAKE_EN_BIT] & i_frame.wake_pkt);

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_frame_accept <= 1'b0;
      o_frame_reject <= 1'b0;
      o_pattern_match <= 1'b0;
    end else begin
      o_frame_accept <= (state_r == ERF_BUSY) & i_frame_end & ~i_frame_abort & hit;
      o_frame_reject <= (state_r == ERF_BUSY) & i_frame_end & ~i_frame_abort & ~hit;
      o_pattern_match <= (state_r == ERF_BUSY) & i_frame_end & pm_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive activity.

  logic rx_live;
  assign rx_live = ctrl_r[ERF_ON_BIT] & ctrl_r[ERF_RECEIVE_ENABLE_CTL_BIT];

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state_r <= ERF_IDLE;
    end else begin
      case (state_r)
        ERF_IDLE: begin
          if (rx_live && i_frame_start) state_r <= ERF_BUSY;
        end
        ERF_BUSY: begin
          // Abort or rejection also ends activity, without a done event.
          if (!ctrl_r[ERF_ON_BIT] || i_frame_end || i_frame_abort) state_r <= ERF_IDLE;
        end
        default: state_r <= ERF_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watermarks, flow control and interrupts.

  logic full_now;
  logic empty_now;
  logic [ERF_IRQ_W-1:0] ev;

  assign full_now = i_rx_buffer_count >= wmark_r[ERF_FULL_LSB +: 8];
  assign empty_now = i_rx_buffer_count <= wmark_r[ERF_EMPTY_LSB +: 8];

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      // The detectors follow the live compare during reset, so that leaving
      // reset with both marks at zero raises no false watermark event.
      full_r <= full_now;
      empty_r <= empty_now;
    end else begin
      full_r <= full_now;
      empty_r <= empty_now;
    end
  end

  // Flow control starts at the full mark and stops at the empty mark;
  // the gap between the two marks gives hysteresis.
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      flow_r <= 1'b0;
    end else if (!ctrl_r[ERF_AUTOFC_BIT] || !ctrl_r[ERF_ON_BIT]) begin
      flow_r <= 1'b0;
    end else if (full_now) begin
      flow_r <= 1'b1;
    end else if (empty_now) begin
      flow_r <= 1'b0;
    end
  end
  assign o_flow_ctl = flow_r;

  always_comb begin
    ev = '0;
    ev[ERF_IRQ_FULL] = full_now & ~full_r;
    ev[ERF_IRQ_EMPTY] = empty_now & ~empty_r;
    ev[ERF_IRQ_DONE] = (state_r == ERF_BUSY) & i_frame_end & ~i_frame_abort & hit;
  end

  // A new event beats a write-one-to-clear in the same cycle.
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      irq_stat_r <= ERF_IRQ_RESET;
    end else if (wr_en && i_paddr == ERF_OFS_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~i_pwdata[ERF_IRQ_W-1:0]) | ev;
    end else begin
      irq_stat_r <= irq_stat_r | ev;
    end
  end

  assign o_irq = |(irq_stat_r & irq_mask_r);

endmodule : erf_rx_filter

// File: rtl/erf_pkg.sv
/*
  Package for the receive filter and watermark block: register offsets,
  field positions, reset values, pattern modes and carrier structs.
  Assumes a 32-bit APB register bus and a single 100 MHz clock.
*/
package erf_pkg;

  // Register byte offsets.
  localparam logic [7:0] ERF_OFS_FILTER = 8'h00;
  localparam logic [7:0] ERF_OFS_WMARK = 8'h04;
  localparam logic [7:0] ERF_OFS_STATUS = 8'h08;
  localparam logic [7:0] ERF_OFS_CTRL = 8'h0c;
  localparam logic [7:0] ERF_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] ERF_OFS_IRQ_MASK = 8'h14;

  // Filter register fields.
  localparam int ERF_HASH_EN_BIT = 15;
  localparam int ERF_WAKE_EN_BIT = 14;
  localparam int ERF_INVERT_BIT = 12;
  localparam int ERF_MODE_LSB = 8;
  localparam logic [31:0] ERF_FILTER_WMASK = 32'h0000_dfff;
  localparam logic [31:0] ERF_FILTER_RESET = 32'h0000_0000;

  // Watermark register fields.
  localparam int ERF_FULL_LSB = 16;
  localparam int ERF_EMPTY_LSB = 0;
  localparam logic [31:0] ERF_WMARK_WMASK = 32'h00ff_00ff;
  localparam logic [31:0] ERF_WMARK_RESET = 32'h0000_0000;

  // Control register: module on, receive enable, automatic flow control.
  localparam int ERF_ON_BIT = 15;
  localparam int ERF_RECEIVE_ENABLE_CTL_BIT = 8;
  localparam int ERF_AUTOFC_BIT = 7;
  localparam logic [31:0] ERF_CTRL_WMASK = 32'h0000_8180;
  localparam logic [31:0] ERF_CTRL_RESET = 32'h0000_0000;

  // Status register: receive active and flow control state.
  localparam int ERF_ACTIVE_BIT = 5;
  localparam int ERF_FC_BIT = 6;

  // Interrupt bits: full mark, empty mark, receive done.
  localparam int ERF_IRQ_W = 3;
  localparam int ERF_IRQ_FULL = 0;
  localparam int ERF_IRQ_EMPTY = 1;
  localparam int ERF_IRQ_DONE = 2;
  localparam logic [ERF_IRQ_W-1:0] ERF_IRQ_RESET = 3'h0;

  // Pattern modes.
  localparam logic [3:0] ERF_PM_OFF = 4'h0;
  localparam logic [3:0] ERF_PM_PLAIN = 4'h1;
  localparam logic [3:0] ERF_PM_STN_A = 4'h2;
  localparam logic [3:0] ERF_PM_STN_B = 4'h3;
  localparam logic [3:0] ERF_PM_UNI_A = 4'h4;
  localparam logic [3:0] ERF_PM_UNI_B = 4'h5;
  localparam logic [3:0] ERF_PM_BC_A = 4'h6;
  localparam logic [3:0] ERF_PM_BC_B = 4'h7;
  localparam logic [3:0] ERF_PM_HASH = 4'h8;
  localparam logic [3:0] ERF_PM_WAKE = 4'h9;

  // Accept class order in the low byte, bit 7 down to bit 0.
  typedef struct packed {
    logic bad_crc;
    logic good_crc;
    logic runt_error;
    logic runt;
    logic unicast;
    logic other_unicast;
    logic multicast;
    logic broadcast;
  } erf_class_t;

  // Per-frame qualifiers supplied at the end of a frame.
  typedef struct packed {
    erf_class_t cls;
    logic csum_match;
    logic station_hit;
    logic hash_hit;
    logic wake_pkt;
  } erf_frame_t;

  typedef enum logic [1:0] {
    ERF_IDLE = 2'b01,
    ERF_BUSY = 2'b10
  } erf_state_t;

endpackage : erf_pkg

// File: tb/erf_asserts.sv
/* Port checker for the receive filter block.
   Bound to erf_rx_filter; shadows the written registers it needs. */
`timescale 1ns/10ps
module erf_asserts
  import erf_pkg::*;
#(
  parameter int COUNT_W = 8
) (
  // Watched ports.
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire erf_frame_t i_frame,
  input wire logic [COUNT_W-1:0] i_rx_buffer_count,
  input wire logic [31:0] o_prdata,
  input wire logic o_frame_accept,
  input wire logic o_frame_reject,
  input wire logic o_pattern_match,
  input wire logic o_hash_filter_on,
  input wire logic o_flow_ctl
);
  logic [31:0] flt_r;
  logic [31:0] wm_r;
  logic [31:0] ctl_r;
  wire logic acc = i_psel && i_penable;
  wire logic fc = ctl_r[ERF_ON_BIT] && ctl_r[ERF_AUTOFC_BIT];
  ////////////////////////////////////////
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      flt_r <= 32'h0;
      wm_r <= 32'h0;
      ctl_r <= 32'h0;
    end else if (acc && i_pwrite) begin
      if (i_paddr == ERF_OFS_FILTER) flt_r <= i_pwdata & ERF_FILTER_WMASK;
      if (i_paddr == ERF_OFS_WMARK) wm_r <= i_pwdata & ERF_WMARK_WMASK;
      if (i_paddr == ERF_OFS_CTRL) ctl_r <= i_pwdata & ERF_CTRL_WMASK;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  sequence s_wr(logic [7:0] a);
    acc && i_pwrite && i_paddr == a;
  endsequence
  // A frame end was taken one edge ago while the given mode was set.
  sequence s_end(logic [3:0] m);
    (o_frame_accept || o_frame_reject) && $past(flt_r[11:8]) == m;
  endsequence
  AST_HASH_ON: assert property (
    s_wr(ERF_OFS_FILTER) |=> o_hash_filter_on == $past(i_pwdata[ERF_HASH_EN_BIT]))
    else $error("hash enable output wrong");
  AST_PM_OFF: assert property (s_end(ERF_PM_OFF) |-> !o_pattern_match)
    else $error("match with pattern mode off");
  AST_PM_PLAIN: assert property (
    s_end(ERF_PM_PLAIN) |-> o_pattern_match == $past(flt_r[12] ^ i_frame.csum_match))
    else $error("plain pattern match wrong");
  AST_PM_HASH: assert property (s_end(ERF_PM_HASH) |->
    o_pattern_match == $past((flt_r[12] ^ i_frame.csum_match) && i_frame.hash_hit))
    else $error("hash pattern match wrong");
  AST_FLOW_ON: assert property (
    fc && $rose(i_rx_buffer_count >= wm_r[23:16]) |=> o_flow_ctl)
    else $error("flow control not started");
  AST_FLOW_OFF: assert property (fc && $rose(i_rx_buffer_count <= wm_r[7:0]) &&
    i_rx_buffer_count < wm_r[23:16] |=> !o_flow_ctl)
    else $error("flow control not stopped");
  AST_OFF_IDLE: assert property (acc && !i_pwrite && i_paddr == ERF_OFS_STATUS &&
    !$past(ctl_r[ERF_ON_BIT]) && !$past(ctl_r[ERF_ON_BIT], 2) |-> !o_prdata[5])
    else $error("active with module off");
  AST_RAZ: assert property (acc && !i_pwrite && i_paddr == ERF_OFS_FILTER |->
    o_prdata[31:16] == 16'h0 && !o_prdata[13])
    else $error("unimplemented filter bits set");
endmodule : erf_asserts

bind erf_rx_filter erf_asserts #(.COUNT_W(COUNT_W)) u_chk (.i_clock(i_clock),
  .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_frame(i_frame),
  .i_rx_buffer_count(i_rx_buffer_count), .o_prdata(o_prdata),
  .o_frame_accept(o_frame_accept), .o_frame_reject(o_frame_reject),
  .o_pattern_match(o_pattern_match), .o_hash_filter_on(o_hash_filter_on),
  .o_flow_ctl(o_flow_ctl));

// File: tb/erf_phy_model.sv
/* Physical-layer side model: delivers one frame per request.
   Qualifiers are valid only with the end or abort pulse; they toggle otherwise. */
`timescale 1ns/10ps
module erf_phy_model
  import erf_pkg::*;
(
  // Requests from the bench.
  input wire logic i_clock,
  input wire logic i_go,
  input wire logic i_cut,
  input wire erf_frame_t i_frm,
  input wire logic [7:0] i_len,
  // Toward the block.
  output logic o_start,
  output logic o_end,
  output logic o_abort,
  output erf_frame_t o_frame,
  output logic o_busy
);
  logic [7:0] cnt_r;
  initial begin
    {o_start, o_end, o_abort, o_busy, cnt_r, o_frame} = '0;
  end
  ////////////////////////////////////////
  always @(posedge i_clock) begin
    o_start <= i_go && !o_busy;
    o_end <= 1'b0;
    o_abort <= 1'b0;
    o_frame <= ~o_frame;
    if (i_go && !o_busy) begin
      o_busy <= 1'b1;
      cnt_r <= i_len;
    end else if (o_busy && cnt_r != 8'h0) begin
      cnt_r <= cnt_r - 8'h1;
    end else if (o_busy) begin
      o_busy <= 1'b0;
      o_end <= !i_cut;
      o_abort <= i_cut;
      o_frame <= i_frm;
    end
  end
endmodule : erf_phy_model

// File: tb/testbench.sv
/* Self-checking bench for erf_rx_filter.
   Drives APB and the frame model; expects the package offsets. */
`timescale 1ns/10ps
module testbench;
  import erf_pkg::*;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0, cut = 1'b0;
  logic [7:0] padr = 8'h0, len = 8'h0, cnt = 8'h0;
  logic [31:0] pwd = 32'h0, prd, q;
  logic prdy, perr, st, en, ab, busy, acc, rej, pm, hon, won, fl, irq;
  erf_frame_t frm = '0, fo;
  int errors = 0, n_compared = 0, n_pm = 0, n_acc = 0, n_rej = 0, p, a, r;
  logic [3:0] m;
  logic v, x;
  logic [11:0] f;
  logic [17:0] rows [14] = '{
    {4'h0, 1'b0, 12'h00f, 1'b0},
    {4'h1, 1'b0, 12'h008, 1'b1},
    {4'h1, 1'b1, 12'h008, 1'b0},
    {4'h1, 1'b1, 12'h000, 1'b1},
    {4'h2, 1'b0, 12'h008, 1'b0},
    {4'h3, 1'b0, 12'h00c, 1'b1},
    {4'h4, 1'b0, 12'h088, 1'b1},
    {4'h5, 1'b0, 12'h008, 1'b0},
    {4'h6, 1'b0, 12'h018, 1'b1},
    {4'h7, 1'b0, 12'h008, 1'b0},
    {4'h8, 1'b0, 12'h00a, 1'b1},
    {4'h8, 1'b0, 12'h008, 1'b0},
    {4'h9, 1'b0, 12'h009, 1'b1},
    {4'h9, 1'b0, 12'h001, 1'b0}};
  always #5 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    n_pm <= n_pm + int'(pm === 1'b1);
    n_acc <= n_acc + int'(acc === 1'b1);
    n_rej <= n_rej + int'(rej === 1'b1);
  end
  erf_phy_model phy (.i_clock(i_clock), .i_go(go), .i_cut(cut), .i_frm(frm),
    .i_len(len), .o_start(st), .o_end(en), .o_abort(ab), .o_frame(fo), .o_busy(busy));
  erf_rx_filter uut (.i_clock(i_clock), .i_rstn(i_rstn), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd),
    .o_pready(prdy), .o_pslverr(perr), .i_frame_start(st), .i_frame_end(en),
    .i_frame_abort(ab), .i_frame(fo), .i_rx_buffer_count(cnt), .o_frame_accept(acc),
    .o_frame_reject(rej), .o_pattern_match(pm), .o_hash_filter_on(hon),
    .o_wake_filter_on(won), .o_flow_ctl(fl), .o_irq(irq));
  ////////////////////////////////////////
  task automatic close_out();
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_clock);
    psel <= 1'b1;
    pwr <= w;
    padr <= ad;
    pwd <= d;
    @(posedge i_clock);
    pen <= 1'b1;
    do @(posedge i_clock); while (prdy !== 1'b1);
    q = prd;
    v = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    chk(q, e);
  endtask : rd
  task automatic send(input logic [11:0] fr, input logic [7:0] n, input logic c);
    @(posedge i_clock);
    go <= 1'b1;
    frm <= fr;
    len <= n;
    cut <= c;
    @(posedge i_clock);
    go <= 1'b0;
  endtask : send
  task automatic fin();
    do @(negedge i_clock); while (busy === 1'b1);
    repeat (3) @(posedge i_clock);
  endtask : fin
  // Filter bits only change with receive disabled.
  task automatic setf(input logic [31:0] d);
    apb(1'b1, ERF_OFS_CTRL, 32'h8000);
    apb(1'b1, ERF_OFS_FILTER, d);
    apb(1'b1, ERF_OFS_CTRL, 32'h8100);
  endtask : setf
  initial begin
    repeat (20000) @(posedge i_clock);
    errors++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge i_clock);
    i_rstn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0);
    rd(8'h20, 32'h0);
    chk(v, 1'b1);
    apb(1'b1, ERF_OFS_FILTER, 32'hffffffff);
    rd(ERF_OFS_FILTER, ERF_FILTER_WMASK);
    chk({hon, won}, 2'b11);
    apb(1'b1, ERF_OFS_WMARK, 32'hffffffff);
    rd(ERF_OFS_WMARK, ERF_WMARK_WMASK);
    for (int i = 0; i < 14; i++) begin
      {m, v, f, x} = rows[i];
      setf({19'h0, v, m, 8'h0});
      chk({hon, won}, 2'b00);
      p = n_pm;
      a = n_acc;
      r = n_rej;
      send(f, 8'd3, 1'b0);
      fin();
      chk(n_pm - p, x);
      chk(n_acc - a, x);
      chk(n_rej - r, !x);
    end
    for (int i = 0; i < 8; i++) begin
      setf(32'h1 << i);
      a = n_acc;
      send({8'h1 << i, 4'h0}, 8'd2, 1'b0);
      fin();
      chk(n_acc - a, 1);
    end
    // Accepted frames leave only the done event pending.
    rd(ERF_OFS_IRQ_STAT, 32'h4);
    send(12'h0, 8'd30, 1'b0);
    rd(ERF_OFS_STATUS, 32'h20);
    apb(1'b1, ERF_OFS_CTRL, 32'h0);
    rd(ERF_OFS_STATUS, 32'h0);
    fin();
    apb(1'b1, ERF_OFS_CTRL, 32'h8100);
    apb(1'b1, ERF_OFS_IRQ_STAT, 32'h7);
    send(12'h0ff, 8'd2, 1'b1);
    fin();
    rd(ERF_OFS_IRQ_STAT, 32'h0);
    rd(ERF_OFS_STATUS, 32'h0);
    apb(1'b1, ERF_OFS_WMARK, 32'h00100004);
    cnt <= 8'h08;
    apb(1'b1, ERF_OFS_CTRL, 32'h8080);
    apb(1'b1, ERF_OFS_IRQ_STAT, 32'h7);
    apb(1'b1, ERF_OFS_IRQ_MASK, 32'h3);
    cnt <= 8'h0f;
    rd(ERF_OFS_IRQ_STAT, 32'h0);
    cnt <= 8'h10;
    rd(ERF_OFS_IRQ_STAT, 32'h1);
    chk({fl, irq}, 2'b11);
    cnt <= 8'h05;
    rd(ERF_OFS_IRQ_STAT, 32'h1);
    cnt <= 8'h04;
    rd(ERF_OFS_IRQ_STAT, 32'h3);
    chk({fl, irq}, 2'b01);
    apb(1'b1, ERF_OFS_IRQ_MASK, 32'h0);
    // The mask write lands at the edge that ended the task; look one edge on.
    @(posedge i_clock);
    chk(irq, 1'b0);
    apb(1'b1, ERF_OFS_IRQ_MASK, 32'h3);
    apb(1'b1, ERF_OFS_IRQ_STAT, 32'h3);
    rd(ERF_OFS_IRQ_STAT, 32'h0);
    chk(irq, 1'b0);
    close_out();
  end
endmodule : testbench
